// [design/hpm_host_port.sv]
// host port: 16-bit bus to 32-bit memories and control register
// ---------------------------------------------------------------
// Functional notes
// - 16-bit bus reaches data, connection memories, control register
// - bus line n carries bit n+16 or n
// - style select low first style, high byte-enable
// - cycle-hold and acknowledge both driven in either style
// - each 32-bit location spans four byte addresses
// - big-endian: lowest address holds bits 31:24
// - half bit zero upper half, one lower
// - lane codes pick bytes to write; 11 writes nothing, reads still return data
// - data memory write stores nothing, signals bus fault unless lane code is 11
// - hold low after strobe, release with ack/fault
// - withdraw on strobe high; tri-state on select high
// - byte-enable style always acknowledges, even on fault
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module hpm_host_port
  import hpm_pkg::*;
#(
  parameter int DMEM_WORDS = 16,  // data memory depth
  parameter int CMEM_WORDS = 16   // connection memory depth
) (
  input  wire logic        ref_clk,           // 20 MHz clock
  input  wire logic        rstn,              // sync reset, active low
  input  wire logic        chip_select_n,     // chip select pin
  input  wire logic        cycle_strobe_n,    // data strobe pin
  input  wire logic        read_not_write,    // 1 = read
  input  wire logic        bus_style_select,  // 0 strobes, 1 byte enables
  input  wire logic [18:0] host_address,      // byte address
  input  wire logic        high_lane_strobe_n,// high lane strobe
  input  wire logic        low_lane_strobe_n, // low lane strobe
  input  wire logic [15:0] host_data_in,      // host data bus in
  output logic      [15:0] host_data_out,     // host data bus out
  output logic             host_data_oe,      // data bus drive enable
  output logic             cycle_hold_n,      // wait output
  output logic             transfer_ack_n,    // acknowledge output
  output logic             bus_fault_n,       // bus error output
  output logic             term_oe,           // enable of the three above
  input  wire logic        dmem_wr_en,        // internal data memory fill
  input  wire logic [$clog2(DMEM_WORDS)-1:0] dmem_wr_idx,  // fill index
  input  wire logic [31:0] dmem_wr_data,      // fill word
  output logic      [31:0] group_zero_stream_control  // register value
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  hpm_pins_type pin_raw, pin_meta_r, pin_s;

  always_comb begin
    pin_raw.cs_n  = chip_select_n;
    pin_raw.ds_n  = cycle_strobe_n;
    pin_raw.rd    = read_not_write;
    pin_raw.style = bus_style_select;
    pin_raw.addr  = host_address;
    pin_raw.hi_n  = high_lane_strobe_n;
    pin_raw.lo_n  = low_lane_strobe_n;
    pin_raw.data  = host_data_in;
  end

  // two flops per pin, second stage only read by logic
  always_ff @(posedge ref_clk) begin
    pin_meta_r <= pin_raw;
    pin_s      <= pin_meta_r;
  end

  // ---------------------------------------------------------------
  // state and captured request
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_END, ST_PARK} hpm_state_type;

  hpm_state_type state_r;
  hpm_req_type   req_r;
  logic [31:0]   dmem [DMEM_WORDS];
  logic [31:0]   cmem [CMEM_WORDS];
  logic [31:0]   grp0_r;
  logic [31:0]   old_word;
  logic [31:0]   new_word;
  logic [15:0]   rdata;
  logic          hit_dmem, hit_cmem, hit_grp0, fault, no_lane;
  logic [16:0]   widx;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    widx     = req_r.addr[18:2];
    hit_dmem = (req_r.addr >= HPM_DMEM_BASE) &&
               (req_r.addr < HPM_DMEM_BASE + 19'(DMEM_WORDS * 4));
    hit_cmem = (req_r.addr >= HPM_CMEM_BASE) &&
               (req_r.addr < HPM_CMEM_BASE + 19'(CMEM_WORDS * 4));
    hit_grp0 = (req_r.addr[18:2] == HPM_GRP0_ADDR[18:2]);
    no_lane  = ({req_r.hi_n, req_r.lo_n} == HPM_LANE_NONE);
    old_word = '0;
    if (hit_dmem) begin
      old_word = dmem[widx[$clog2(DMEM_WORDS)-1:0] - HPM_DMEM_BASE[$clog2(DMEM_WORDS)+1:2]];
    end else if (hit_cmem) begin
      old_word = cmem[widx[$clog2(CMEM_WORDS)-1:0]];
    end else if (hit_grp0) begin
      old_word = grp0_r;
    end
    // unmapped, or write into data memory, is a bus fault unless no lane is strobed (11)
    fault = !no_lane && ((!hit_dmem && !hit_cmem && !hit_grp0) ||
                         (hit_dmem && !req_r.rd));
  end

  // big-endian lane steering, half bit is address bit 1
  hpm_lane_mux u_lane (
    .old_word (old_word),
    .wdata    (req_r.wdata),
    .half     (req_r.addr[1]),
    .hi_n     (req_r.hi_n),
    .lo_n     (req_r.lo_n),
    .new_word (new_word),
    .rdata    (rdata)
  );

  // ---------------------------------------------------------------
  // bus cycle sequencer and termination outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r        <= ST_IDLE;
      req_r          <= '0;
      cycle_hold_n   <= 1'b1;
      transfer_ack_n <= 1'b1;
      bus_fault_n    <= 1'b1;
      term_oe        <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          term_oe <= !pin_s.cs_n;
          if (!pin_s.cs_n && !pin_s.ds_n) begin
            req_r.rd    <= pin_s.rd;
            req_r.addr  <= pin_s.addr;
            req_r.hi_n  <= pin_s.hi_n;
            req_r.lo_n  <= pin_s.lo_n;
            req_r.wdata <= pin_s.data;
            cycle_hold_n <= 1'b0;
            state_r      <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cycle_hold_n <= 1'b1;
          bus_fault_n  <= !fault;
          // byte-enable style acknowledges even with a fault
          transfer_ack_n <= fault && !pin_s.style;
          state_r        <= ST_END;
        end
        ST_END: begin
          if (pin_s.ds_n) begin
            transfer_ack_n <= 1'b1;
            bus_fault_n    <= 1'b1;
            state_r        <= ST_IDLE;
          end else if (pin_s.cs_n) begin
            // select left before strobe: drive inactive, then release
            transfer_ack_n <= 1'b1;
            bus_fault_n    <= 1'b1;
            state_r        <= ST_PARK;
          end
        end
        ST_PARK: begin
          term_oe <= 1'b0;
          if (pin_s.ds_n) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      host_data_out <= 16'h0000;
      host_data_oe  <= 1'b0;
    end else begin
      if (state_r == ST_HOLD && req_r.rd) begin
        host_data_out <= rdata;
        host_data_oe  <= 1'b1;
      end else if (pin_s.cs_n) begin
        host_data_oe  <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // storage: writes only for valid, strobed cycles
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      grp0_r <= HPM_GRP0_RST;
    end else if (state_r == ST_HOLD && !req_r.rd && !fault && !no_lane) begin
      if (hit_grp0) begin
        grp0_r <= new_word;
      end
    end
  end

  // connection memory, no reset on array contents
  always_ff @(posedge ref_clk) begin
    if (state_r == ST_HOLD && !req_r.rd && !fault && !no_lane && hit_cmem) begin
      cmem[widx[$clog2(CMEM_WORDS)-1:0]] <= new_word;
    end
  end

  // data memory is filled from the switch side only
  always_ff @(posedge ref_clk) begin
    if (dmem_wr_en) begin
      dmem[dmem_wr_idx] <= dmem_wr_data;
    end
  end

  // register value out
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      group_zero_stream_control <= HPM_GRP0_RST;
    end else begin
      group_zero_stream_control <= grp0_r;
    end
  end

endmodule : hpm_host_port
`default_nettype wire

// [design/hpm_pkg.sv]
// shared constants and carrier types for the host port byte lane mapper
package hpm_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int HPM_ADDR_W = 19;
  localparam int HPM_DATA_W = 16;
  localparam int HPM_WORD_W = 32;

  // ---------------------------------------------------------------
  // address map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [18:0] HPM_DMEM_BASE = 19'h00000;  // data memory, read only
  localparam logic [18:0] HPM_CMEM_BASE = 19'h10000;  // connection memory
  localparam logic [18:0] HPM_GRP0_ADDR = 19'h40200;  // group_zero_stream_control

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] HPM_GRP0_RST = 32'h000c000c;

  // ---------------------------------------------------------------
  // lane strobe codes {high, low}, active low
  // ---------------------------------------------------------------
  localparam logic [1:0] HPM_LANE_NONE = 2'b11;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        rd;        // 1 = read cycle
    logic [18:0] addr;      // host byte address
    logic        hi_n;      // high lane strobe
    logic        lo_n;      // low lane strobe
    logic [15:0] wdata;     // write data from host
  } hpm_req_type;

  typedef struct packed {
    logic        cs_n;
    logic        ds_n;
    logic        rd;
    logic        style;
    logic [18:0] addr;
    logic        hi_n;
    logic        lo_n;
    logic [15:0] data;
  } hpm_pins_type;

endpackage : hpm_pkg

// [design/hpm_lane_mux.sv]
// byte lane steering between the 16-bit host bus and a 32-bit word
`timescale 1ns/100ps
`default_nettype none
module hpm_lane_mux
  import hpm_pkg::*;
(
  input  wire logic [31:0] old_word,   // current content of location
  input  wire logic [15:0] wdata,      // host write data
  input  wire logic        half,       // word half select
  input  wire logic        hi_n,       // high lane strobe
  input  wire logic        lo_n,       // low lane strobe
  output logic      [31:0] new_word,   // merged word for writes
  output logic      [15:0] rdata       // half word for reads
);

  // read: upper or lower half onto the bus
  always_comb begin
    rdata = half ? old_word[15:0] : old_word[31:16];
  end

  // write: only strobed lanes of the chosen half change
  always_comb begin
    new_word = old_word;
    if (!half) begin
      if (!hi_n) new_word[31:24] = wdata[15:8];
      if (!lo_n) new_word[23:16] = wdata[7:0];
    end else begin
      if (!hi_n) new_word[15:8]  = wdata[15:8];
      if (!lo_n) new_word[7:0]   = wdata[7:0];
    end
  end

endmodule : hpm_lane_mux
`default_nettype wire

// [verif/hpm_host_port_props.sv]
// assertions on the host port pins and register output
`timescale 1ns/100ps
`default_nettype none
module hpm_host_port_props
  import hpm_pkg::*;
(
  input wire logic        ref_clk,          // port clock
  input wire logic        rstn,             // sync reset
  input wire logic        chip_select_n,    // chip select pin
  input wire logic        cycle_strobe_n,   // data strobe pin
  input wire logic        read_not_write,   // read cycle pin
  input wire logic        bus_style_select, // bus style pin
  input wire logic        host_data_oe,     // data drive enable
  input wire logic        cycle_hold_n,     // wait output
  input wire logic        transfer_ack_n,   // acknowledge
  input wire logic        bus_fault_n,      // bus error
  input wire logic        term_oe,          // termination enable
  input wire logic [31:0] group_zero_stream_control // register value
);
  // all checks on the port clock, idle in reset except reset_idle_a
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  reset_idle_a: assert property (disable iff (1'b0)
    !rstn ##1 !rstn |-> cycle_hold_n && transfer_ack_n && bus_fault_n && !term_oe
    && !host_data_oe && group_zero_stream_control == HPM_GRP0_RST) else $error("reset state");
  hold_start_a: assert property ($fell(cycle_strobe_n) && !chip_select_n
    |-> ##[1:5] !cycle_hold_n) else $error("no hold after strobe");
  hold_pulse_a: assert property ($fell(cycle_hold_n) |=>
    cycle_hold_n && !(transfer_ack_n && bus_fault_n)) else $error("hold release");
  ack_after_hold_a: assert property ($fell(transfer_ack_n) |->
    !$past(cycle_hold_n)) else $error("ack without hold");
  fault_style_a: assert property (!bus_fault_n |->
    transfer_ack_n == !bus_style_select) else $error("ack with fault");
  term_drive_a: assert property (!(cycle_hold_n && transfer_ack_n && bus_fault_n)
    |-> term_oe) else $error("termination undriven");
  strobe_withdraw_a: assert property ($rose(cycle_strobe_n) |->
    ##[1:4] (transfer_ack_n && bus_fault_n)) else $error("ack not withdrawn");
  select_release_a: assert property (chip_select_n [*5] |->
    !host_data_oe && !term_oe) else $error("bus not released");
  read_drive_a: assert property ($fell(cycle_hold_n) && read_not_write |=>
    host_data_oe) else $error("read data not driven");
  park_order_a: assert property ($fell(term_oe) |->
    $past(transfer_ack_n) && $past(bus_fault_n) && $past(cycle_hold_n))
    else $error("termination released while active");
endmodule : hpm_host_port_props

bind hpm_host_port hpm_host_port_props hpm_host_port_props_i (.ref_clk(ref_clk),
  .rstn(rstn), .chip_select_n(chip_select_n), .cycle_strobe_n(cycle_strobe_n),
  .read_not_write(read_not_write),
  .bus_style_select(bus_style_select), .host_data_oe(host_data_oe),
  .cycle_hold_n(cycle_hold_n), .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n),
  .term_oe(term_oe), .group_zero_stream_control(group_zero_stream_control));
`default_nettype wire

// [verif/hpm_host_model.sv]
// host processor model driving the 16-bit port pins
`timescale 1ns/100ps
`default_nettype none
module hpm_host_model
  import hpm_pkg::*;
(
  input  wire logic        ref_clk, // port clock
  input  wire logic        ack_n,   // acknowledge from port
  input  wire logic        fault_n, // bus error from port
  input  wire logic [15:0] rdata,   // read data from port
  output var hpm_pins_type pins     // host side pins
);
  // idle bus: deselected, no lanes
  initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 19'h00000, 1'b1, 1'b1, 16'h0000};

  // style pin moves only while idle
  task automatic set_style(input logic s);
    @(posedge ref_clk) #1;
    pins.style = s;
    repeat (4) @(posedge ref_clk);
  endtask : set_style

  // one whole bus cycle, held until terminated
  task automatic xfer(input logic r, input logic [18:0] a, input logic [1:0] ln,
                      input logic [15:0] wd, output logic [15:0] rv,
                      output logic ak, output logic ft, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk) #1;
    pins.cs_n = 1'b0;
    pins.rd = r;
    pins.addr = a;
    {pins.hi_n, pins.lo_n} = ln;
    pins.data = r ? ~pins.data : wd;
    pins.ds_n = 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_n !== 1'b0 && fault_n !== 1'b0 && n < 20);
    ok = (n < 20);
    rv = rdata;
    ak = ack_n;
    ft = fault_n;
    #1 pins.ds_n = 1'b1;
    n = 0;
    while ((ack_n !== 1'b1 || fault_n !== 1'b1) && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    ok = ok && (n < 20);
    #1 pins.cs_n = 1'b1;
    pins.data = ~pins.data;
    repeat (4) @(posedge ref_clk);
  endtask : xfer

  // read whose select leaves before the strobe; ack sampled after select rises
  task automatic cut(input logic [18:0] a, output logic ak);
    @(posedge ref_clk) #1;
    pins.cs_n = 1'b0;
    pins.rd = 1'b1;
    pins.addr = a;
    {pins.hi_n, pins.lo_n} = 2'b00;
    pins.ds_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 pins.cs_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    ak = ack_n;
    #1 pins.ds_n = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : cut
endmodule : hpm_host_model
`default_nettype wire

// [verif/test_host_port_byte_lane_mapper.sv]
// self-checking bench for the host port byte lane mapper
`timescale 1ns/100ps
`default_nettype none
module test_host_port_byte_lane_mapper;
  import hpm_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [18:0] a;
    logic [1:0]  ln;
    logic        flt;
    logic [15:0] d;
  } hpm_row_type;
  logic ref_clk, rstn, ak, ft, ok, fill_en, doe;
  logic [15:0] rdv, dout;
  logic [31:0] grp, fill_d;
  logic [3:0] fill_i;
  hpm_pins_type pins;
  int failures = 0;
  int checked = 0;
  // rows: read flag, address, lanes {hi,lo}, fault, data
  hpm_row_type rows [17] = '{
    {1'b1, 19'h40200, 2'b00, 1'b0, 16'h000c}, {1'b1, 19'h40202, 2'b00, 1'b0, 16'h000c},
    {1'b0, 19'h40200, 2'b01, 1'b0, 16'haabb}, {1'b0, 19'h40201, 2'b10, 1'b0, 16'hccdd},
    {1'b0, 19'h40202, 2'b00, 1'b0, 16'h1234}, {1'b0, 19'h40203, 2'b11, 1'b0, 16'hffff},
    {1'b1, 19'h40200, 2'b00, 1'b0, 16'haadd}, {1'b1, 19'h40202, 2'b11, 1'b0, 16'h1234},
    {1'b0, 19'h10004, 2'b00, 1'b0, 16'h5a5a}, {1'b0, 19'h10006, 2'b00, 1'b0, 16'ha5c3},
    {1'b1, 19'h10004, 2'b00, 1'b0, 16'h5a5a}, {1'b1, 19'h10006, 2'b01, 1'b0, 16'ha5c3},
    {1'b1, 19'h00004, 2'b00, 1'b0, 16'h1122}, {1'b1, 19'h00006, 2'b00, 1'b0, 16'h3344},
    {1'b0, 19'h00004, 2'b00, 1'b1, 16'hffff}, {1'b1, 19'h00004, 2'b00, 1'b0, 16'h1122},
    {1'b1, 19'h7fff0, 2'b00, 1'b1, 16'h0000}};
  wire logic ak_w, ft_w;
  wire logic [15:0] bus_w;

  hpm_host_port hpm_host_port_i (.ref_clk(ref_clk), .rstn(rstn), .chip_select_n(pins.cs_n),
    .cycle_strobe_n(pins.ds_n), .read_not_write(pins.rd), .bus_style_select(pins.style),
    .host_address(pins.addr), .high_lane_strobe_n(pins.hi_n), .low_lane_strobe_n(pins.lo_n),
    .host_data_in(pins.data), .host_data_out(dout), .host_data_oe(doe), .cycle_hold_n(),
    .transfer_ack_n(ak_w), .bus_fault_n(ft_w), .term_oe(), .dmem_wr_en(fill_en),
    .dmem_wr_idx(fill_i), .dmem_wr_data(fill_d), .group_zero_stream_control(grp));
  // undriven data bus shows the inverse of the last value
  assign bus_w = doe ? dout : ~dout;
  hpm_host_model hpm_host_model_i (.ref_clk(ref_clk), .ack_n(ak_w), .fault_n(ft_w),
    .rdata(bus_w), .pins(pins));

  // counted comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // 50 ns port clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    {fill_en, fill_i, fill_d} = {1'b0, 4'h0, 32'h00000000};
    repeat (12) @(posedge ref_clk);
    check(grp, HPM_GRP0_RST);
    #1 rstn = 1'b1;
    @(posedge ref_clk) #1;
    {fill_en, fill_i, fill_d} = {1'b1, 4'h1, 32'h11223344};
    @(posedge ref_clk) #1;
    fill_en = 1'b0;
    for (int s = 0; s < 2; s++) begin
      // register back to its reset value before the second pass
      if (s > 0) begin
        #1 rstn = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 rstn = 1'b1;
      end
      hpm_host_model_i.set_style(s[0]);
      foreach (rows[i]) begin
        hpm_host_model_i.xfer(rows[i].rd, rows[i].a, rows[i].ln, rows[i].d, rdv, ak, ft, ok);
        check({31'h0, ok}, 32'h1);
        check({30'h0, ak, ft}, {30'h0, rows[i].flt & ~s[0], ~rows[i].flt});
        if (rows[i].rd) check({16'h0, rdv}, {16'h0, rows[i].d});
      end
      check(grp, 32'haadd1234);
      $display("style %0d table done", s);
    end
    @(posedge ref_clk) #1;
    rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    check(grp, HPM_GRP0_RST);
    #1 rstn = 1'b1;
    hpm_host_model_i.xfer(1'b1, 19'h40200, 2'b00, 16'h0000, rdv, ak, ft, ok);
    check({31'h0, ok}, 32'h1);
    check({16'h0, rdv}, 32'h0000000c);
    $display("mid-run reset done");
    hpm_host_model_i.cut(19'h40202, ak);
    check({31'h0, ak}, 32'h1);
    $display("select cut done");
    complete_run();
  end
endmodule : test_host_port_byte_lane_mapper
`default_nettype wire
